// *** rtl/dsp_post_defines.vh ***
// Constants for the accumulator saturate, round and shift datapath
`ifndef DSP_POST_DEFINES_VH
`define DSP_POST_DEFINES_VH

// APB register byte offsets
`define REG_CORE_CONFIG      8'h00
`define REG_INTERRUPT_CTRL   8'h04
`define REG_STATUS           8'h08
`define REG_ACC_A_LOW        8'h0C
`define REG_ACC_A_HIGH       8'h10
`define REG_ACC_B_LOW        8'h14
`define REG_ACC_B_HIGH       8'h18
`define REG_WB_POINTER       8'h1C

// Core configuration register fields
`define CFG_ROUND_MODE_BIT   0
`define CFG_DW_SAT_BIT       1
`define CFG_SAT_WIDTH_BIT    4
`define CFG_SAT_B_BIT        6
`define CFG_SAT_A_BIT        7
`define CFG_WRITE_MASK       8'hD3
`define CFG_RESET            8'h00

// Interrupt control fields
`define ICTL_COV_TRAP_BIT    0

// Status register fields
`define ST_SAT_A_BIT         0
`define ST_SAT_B_BIT         1
`define ST_GUARD_A_BIT       2
`define ST_GUARD_B_BIT       3
`define ST_EITHER_GUARD_BIT  4
`define ST_EITHER_SAT_BIT    5
`define ST_TRAP_BIT          6

// Operation codes from the instruction sequencer
`define OP_ADD               3'h0
`define OP_MAC               3'h1
`define OP_MSC               3'h2
`define OP_MPY               3'h3
`define OP_MPY_NEG           3'h4
`define OP_SAC               3'h5
`define OP_SAC_ROUND         3'h6
`define OP_SHIFT             3'h7

// Saturation limits
`define SAT40_POS            40'h7FFFFFFFFF
`define SAT40_NEG            40'h8000000000
`define SAT32_POS            40'h007FFFFFFF
`define SAT32_NEG            40'hFF80000000
`define SAT16_POS            16'h7FFF
`define SAT16_NEG            16'h8000
`define ROUND_HALF           16'h8000

// Reset values and pointer step
`define ACC_RESET            40'h0000000000
`define PTR_RESET            16'h0000
`define PTR_STEP             16'h0002

`endif

// *** rtl/store_word_former.v ***
// Round logic and data-space write saturation for accumulator stores
`timescale 1ns/100ps
`include "dsp_post_defines.vh"

module store_word_former
(
	input  wire [39:0] acc,
	input  wire        round_en,
	input  wire        convergent,
	input  wire        sat_en,
	output reg  [15:0] word
);

	wire [15:0] low_word;
	wire        at_half;
	wire        bump;
	wire [24:0] value;
	wire        too_big;
	wire        too_small;

	////////////////////////////////////////////////////////////////////////////////
	// Round increment: low word at or above half bumps the high word
	assign low_word = acc[15:0];
	assign at_half = (low_word == `ROUND_HALF);
	// Exact half under convergent mode only bumps odd high words, removing bias
	assign bump = round_en & low_word[15] & ~(convergent & at_half & ~acc[16]);

	// Sign comes from bit 39; the extra top bit carries the round adder overflow
	assign value = {acc[39], acc[39:16]} + {24'h000000, bump};
	assign too_big = ~value[24] & (|value[23:15]);
	assign too_small = value[24] & ~(&value[23:15]);

	////////////////////////////////////////////////////////////////////////////////
	// Truncated or rounded 1.15 word, clamped only when saturation is on
	always @*
	begin
		word = value[15:0];
		if (sat_en && too_big)
			word = `SAT16_POS;
		else if (sat_en && too_small)
			word = `SAT16_NEG;
	end

endmodule // store_word_former

// *** rtl/dsp_accumulator_saturate_round_shift.v ***
// Dual 40-bit accumulator post-processing: saturation, flags, store, write-back, shifter
//
// How it works
// - Saturation flags update on every adder pass; only software clears them.
// - Range overflow is judged at bit 31 or bit 39 per width select.
// - With saturation off, the saturation flag shows bit-39 overflow only.
// - Trap enable plus saturation off plus a set flag raises the trap.
// - Combined flags are the OR of both guard and both saturation flags.
// - 40-bit mode loads the 40-bit extreme on bit-39 overflow and flags it.
// - 32-bit mode loads sign-extended 32-bit extreme on bit-31 overflow, flags it.
// - In 32-bit mode the guard overflow flags are never set.
// - Saturation off lets the accumulator wrap, flags bit-39 overflow, may trap.
// - Multiply-accumulate ops may write back the other accumulator's rounded high word.
// - Write-back goes into the pointer, or to its address then pointer plus 2.
// - Round mode picks conventional or convergent; no rounding truncates.
// - Conventional rounding bumps the high word when low word is 0x8000 or more.
// - Convergent rounding bumps at exactly 0x8000 only when bit 16 is one.
// - Plain store truncates, rounded store and write-back round, all saturate when data saturation is on.
// - Data saturation writes 0x7FFF for values above 0x007FFF.
// - Data saturation writes 0x8000 for values below 0xFF8000.
// - Data saturation takes sign from bit 39 and leaves the accumulator alone.
// - With data saturation off, the stored word passes unmodified.
// - One-cycle shifter: right up to 15, left up to 16, from accumulators or X.
// - Signed count: positive right, negative left, zero unchanged.
// - 40-bit results for accumulator shifts, 16-bit for X; X placed per direction.
// - Per-accumulator enables and width select steer accumulator saturation.
// - Guard overflow flag sets when bits 32 to 39 are not all equal.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "dsp_post_defines.vh"

module dsp_accumulator_saturate_round_shift
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        op_valid,
	input  wire [2:0]  op_code,
	input  wire        op_target,
	input  wire [39:0] op_operand,
	input  wire        op_wb_en,
	input  wire        op_wb_indirect,
	input  wire [15:0] op_addr,
	input  wire [4:0]  shift_count,
	input  wire [1:0]  shift_src,
	input  wire        shift_arith,
	input  wire        shift_mcu,
	input  wire [15:0] x_rdata,
	output reg         xw_valid,
	output reg  [15:0] xw_addr,
	output reg  [15:0] xw_data,
	output wire        acc_a_saturated_flag,
	output wire        acc_b_saturated_flag,
	output wire        acc_a_guard_overflow_flag,
	output wire        acc_b_guard_overflow_flag,
	output wire        either_guard_overflow_flag,
	output wire        either_saturated_flag,
	output wire        arith_trap
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// High when guard bits 39..32 do not all agree
	function guard_mixed;
		input [39:0] v;
		begin
			guard_mixed = ~((&v[39:32]) | ~(|v[39:32]));
		end
	endfunction

	// Barrel shift; count is signed, negative means left
	function [39:0] barrel;
		input [39:0] d;
		input [4:0]  cnt;
		input        arith;
		reg   [5:0]  mag;
		reg   [39:0] fill;
		begin
			mag = ~{cnt[4], cnt} + 6'h01;
			fill = {40{arith & d[39]}};
			if (cnt[4])
				barrel = d << mag;
			else
				barrel = (d >> cnt) | (fill & ~({40{1'b1}} >> cnt));
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State

	reg  [39:0] acc_a_r;
	reg  [39:0] acc_b_r;
	reg  [7:0]  core_configuration_register_r;
	reg         catastrophic_overflow_trap_enable_r;
	reg         sat_a_r;
	reg         sat_b_r;
	reg         guard_a_r;
	reg         guard_b_r;
	reg  [15:0] writeback_pointer_register_r;

	// Configuration fields
	wire        round_mode_select;
	wire        data_write_saturation_enable;
	wire        saturation_width_select;
	wire        acc_a_saturation_enable;
	wire        acc_b_saturation_enable;

	assign round_mode_select = core_configuration_register_r[`CFG_ROUND_MODE_BIT];
	assign data_write_saturation_enable = core_configuration_register_r[`CFG_DW_SAT_BIT];
	assign saturation_width_select = core_configuration_register_r[`CFG_SAT_WIDTH_BIT];
	assign acc_a_saturation_enable = core_configuration_register_r[`CFG_SAT_A_BIT];
	assign acc_b_saturation_enable = core_configuration_register_r[`CFG_SAT_B_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Operand selection and 40-bit adder/subtracter

	wire [39:0] acc_tgt;
	wire [39:0] acc_other;
	wire        is_sub;
	wire        is_load;
	wire        is_adder_op;
	wire [39:0] add_a;
	wire [39:0] add_b;
	wire [40:0] sum;
	wire        ov39;
	wire        ov31;
	wire        sat_en_tgt;

	assign acc_tgt = op_target ? acc_b_r : acc_a_r;
	assign acc_other = op_target ? acc_a_r : acc_b_r;
	assign is_sub = (op_code == `OP_MSC) | (op_code == `OP_MPY_NEG);
	assign is_load = (op_code == `OP_MPY) | (op_code == `OP_MPY_NEG);
	assign is_adder_op = op_valid & (op_code <= `OP_MPY_NEG);
	assign add_a = is_load ? `ACC_RESET : acc_tgt;
	assign add_b = is_sub ? ~op_operand : op_operand;
	// One extra bit keeps the true sign past a bit-39 overflow
	assign sum = {add_a[39], add_a} + {add_b[39], add_b} + {40'h0000000000, is_sub};
	assign ov39 = sum[40] ^ sum[39];
	assign ov31 = ~((&sum[40:31]) | ~(|sum[40:31]));
	assign sat_en_tgt = op_target ? acc_b_saturation_enable : acc_a_saturation_enable;

	////////////////////////////////////////////////////////////////////////////////
	// Accumulator saturation: picks result, saturation event and guard flag

	reg  [39:0] add_res;
	reg         sat_hit;
	reg         guard_hit;

	always @*
	begin
		add_res = sum[39:0];
		sat_hit = ov39;
		guard_hit = guard_mixed(sum[39:0]);
		if (sat_en_tgt && saturation_width_select)
		begin
			// 40-bit super saturation
			if (ov39)
				add_res = sum[40] ? `SAT40_NEG : `SAT40_POS;
			guard_hit = guard_mixed(add_res);
		end
		else if (sat_en_tgt)
		begin
			// 32-bit saturation: guard bits unused
			sat_hit = ov31;
			if (ov31)
				add_res = sum[40] ? `SAT32_NEG : `SAT32_POS;
			guard_hit = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Barrel shifter

	wire        shift_left;
	wire [39:0] shift_in;
	wire [39:0] shift_out;
	wire [15:0] shift_word;
	wire        is_shift;

	assign is_shift = op_valid & (op_code == `OP_SHIFT);
	assign shift_left = shift_count[4];
	// X data sits high for right shifts so bits fall into the low word
	assign shift_in = (shift_src == 2'h0) ? acc_a_r :
		(shift_src == 2'h1) ? acc_b_r :
		shift_left ? {24'h000000, x_rdata} :
		{{8{shift_arith & x_rdata[15]}}, x_rdata, 16'h0000};
	assign shift_out = barrel(shift_in, shift_count, shift_arith);
	assign shift_word = shift_left ? shift_out[15:0] : shift_out[31:16];

	////////////////////////////////////////////////////////////////////////////////
	// Store word former: target for stores, other accumulator for write-back

	wire        is_store;
	wire        wb_allowed;
	wire [15:0] store_word;

	assign is_store = op_valid & ((op_code == `OP_SAC) | (op_code == `OP_SAC_ROUND));
	// Plain and negated multiply never write back
	assign wb_allowed = op_valid & op_wb_en &
		((op_code == `OP_MAC) | (op_code == `OP_MSC));

	store_word_former u_former
	(
		.acc        (is_store ? acc_tgt : acc_other),
		.round_en   (~(is_store & (op_code == `OP_SAC))),
		.convergent (round_mode_select),
		.sat_en     (data_write_saturation_enable),
		.word       (store_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: zero-wait access, read data captured in the setup cycle

	wire        apb_setup;
	wire        apb_write;
	wire        addr_ok;
	reg  [31:0] rd_mux;

	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;
	assign addr_ok = (paddr[1:0] == 2'h0) & (paddr <= `REG_WB_POINTER);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	always @*
	begin
		rd_mux = 32'h00000000;
		case (paddr)
			`REG_CORE_CONFIG: rd_mux = {24'h000000, core_configuration_register_r};
			`REG_INTERRUPT_CTRL: rd_mux = {31'h00000000, catastrophic_overflow_trap_enable_r};
			`REG_STATUS: rd_mux = {25'h0000000, arith_trap, either_saturated_flag,
				either_guard_overflow_flag, guard_b_r, guard_a_r, sat_b_r, sat_a_r};
			`REG_ACC_A_LOW: rd_mux = acc_a_r[31:0];
			`REG_ACC_A_HIGH: rd_mux = {24'h000000, acc_a_r[39:32]};
			`REG_ACC_B_LOW: rd_mux = acc_b_r[31:0];
			`REG_ACC_B_HIGH: rd_mux = {24'h000000, acc_b_r[39:32]};
			`REG_WB_POINTER: rd_mux = {16'h0000, writeback_pointer_register_r};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Read data held from setup through access
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (apb_setup && !pwrite)
			prdata <= rd_mux;
	end

	// Configuration and trap enable registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_configuration_register_r <= `CFG_RESET;
			catastrophic_overflow_trap_enable_r <= 1'b0;
		end
		else if (apb_write && paddr == `REG_CORE_CONFIG)
			core_configuration_register_r <= pwdata[7:0] & `CFG_WRITE_MASK;
		else if (apb_write && paddr == `REG_INTERRUPT_CTRL)
			catastrophic_overflow_trap_enable_r <= pwdata[`ICTL_COV_TRAP_BIT];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags

	wire clr_a;
	wire clr_b;
	wire set_a;
	wire set_b;

	// Write one to clear; a same-cycle saturation event wins over the clear
	assign clr_a = apb_write & (paddr == `REG_STATUS) & pwdata[`ST_SAT_A_BIT];
	assign clr_b = apb_write & (paddr == `REG_STATUS) & pwdata[`ST_SAT_B_BIT];
	assign set_a = is_adder_op & ~op_target & sat_hit;
	assign set_b = is_adder_op & op_target & sat_hit;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sat_a_r <= 1'b0;
			sat_b_r <= 1'b0;
			guard_a_r <= 1'b0;
			guard_b_r <= 1'b0;
		end
		else
		begin
			sat_a_r <= set_a | (sat_a_r & ~clr_a);
			sat_b_r <= set_b | (sat_b_r & ~clr_b);
			// Guard flags follow the latest pass through the adder only
			if (is_adder_op && !op_target)
				guard_a_r <= guard_hit;
			if (is_adder_op && op_target)
				guard_b_r <= guard_hit;
		end
	end

	assign acc_a_saturated_flag = sat_a_r;
	assign acc_b_saturated_flag = sat_b_r;
	assign acc_a_guard_overflow_flag = guard_a_r;
	assign acc_b_guard_overflow_flag = guard_b_r;
	assign either_guard_overflow_flag = guard_a_r | guard_b_r;
	assign either_saturated_flag = sat_a_r | sat_b_r;
	// Trap is a level; it only counts flags of accumulators running unsaturated
	assign arith_trap = catastrophic_overflow_trap_enable_r &
		((sat_a_r & ~acc_a_saturation_enable) |
		(sat_b_r & ~acc_b_saturation_enable));

	////////////////////////////////////////////////////////////////////////////////
	// Accumulators: adder results or accumulator-destined shifts

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_a_r <= `ACC_RESET;
			acc_b_r <= `ACC_RESET;
		end
		else if (is_adder_op)
		begin
			// Stores never reach this path, so data saturation leaves acc intact
			if (op_target)
				acc_b_r <= add_res;
			else
				acc_a_r <= add_res;
		end
		else if (is_shift && !shift_mcu)
		begin
			if (op_target)
				acc_b_r <= shift_out;
			else
				acc_a_r <= shift_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// X bus writes and write-back pointer

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xw_valid <= 1'b0;
			xw_addr <= 16'h0000;
			xw_data <= 16'h0000;
			writeback_pointer_register_r <= `PTR_RESET;
		end
		else
		begin
			xw_valid <= 1'b0;
			if (is_store)
			begin
				xw_valid <= 1'b1;
				xw_addr <= op_addr;
				xw_data <= store_word;
			end
			else if (is_shift && shift_mcu)
			begin
				xw_valid <= 1'b1;
				xw_addr <= op_addr;
				xw_data <= shift_word;
			end
			else if (wb_allowed && op_wb_indirect)
			begin
				// Indirect write-back then post-increment by one word
				xw_valid <= 1'b1;
				xw_addr <= writeback_pointer_register_r;
				xw_data <= store_word;
				writeback_pointer_register_r <= writeback_pointer_register_r +
					`PTR_STEP;
			end
			else if (wb_allowed)
				writeback_pointer_register_r <= store_word;
			// Software pointer loads lose to a write-back in the same cycle
			if (apb_write && paddr == `REG_WB_POINTER && !wb_allowed)
				writeback_pointer_register_r <= pwdata[15:0];
		end
	end

endmodule // dsp_accumulator_saturate_round_shift

// *** verification/dsp_post_props.sv ***
// Port-level assertions for the accumulator post-processing datapath
`timescale 1ns/100ps
`include "dsp_post_defines.vh"

module dsp_post_props
(
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire        op_valid,
	input wire [2:0]  op_code,
	input wire        op_target,
	input wire [15:0] op_addr,
	input wire        xw_valid,
	input wire [15:0] xw_addr,
	input wire        acc_a_saturated_flag,
	input wire        acc_b_saturated_flag,
	input wire        acc_a_guard_overflow_flag,
	input wire        acc_b_guard_overflow_flag,
	input wire        either_guard_overflow_flag,
	input wire        either_saturated_flag,
	input wire        arith_trap
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);

wire       apb_wr = psel && penable && pwrite;
wire       adder_op = op_valid && (op_code <= `OP_MPY_NEG);
reg  [7:0] cfg_r;

////////////////////////////////////////////////////////////////////////
// Shadow of the configuration register, since the mode is not a port
always @(posedge pclk or negedge presetn)
	if (!presetn)
		cfg_r <= 8'h00;
	else if (apb_wr && paddr == `REG_CORE_CONFIG)
		cfg_r <= pwdata[7:0];

////////////////////////////////////////////////////////////////////////
chk_sat_sticky: assert property (
	acc_a_saturated_flag && !(apb_wr && paddr == `REG_STATUS && pwdata[0])
	|=> acc_a_saturated_flag) else $error("A saturation flag dropped without clear");
chk_sat_cause: assert property (
	$rose(acc_a_saturated_flag) |-> $past(adder_op))
	else $error("A saturation flag rose without an adder pass");
chk_either_sat: assert property (
	either_saturated_flag == (acc_a_saturated_flag || acc_b_saturated_flag))
	else $error("Combined saturation flag wrong");
chk_either_guard: assert property (
	either_guard_overflow_flag == (acc_a_guard_overflow_flag || acc_b_guard_overflow_flag))
	else $error("Combined guard flag wrong");
chk_trap_cause: assert property (
	arith_trap |-> (acc_a_saturated_flag && !cfg_r[7]) || (acc_b_saturated_flag && !cfg_r[6]))
	else $error("Trap without an unsaturated flagged accumulator");
chk_guard_unused: assert property (
	adder_op && !op_target && cfg_r[7] && !cfg_r[4] |=> !acc_a_guard_overflow_flag)
	else $error("Guard flag set in 32-bit saturation");
chk_store_write: assert property (
	op_valid && (op_code == `OP_SAC || op_code == `OP_SAC_ROUND)
	|=> xw_valid && xw_addr == $past(op_addr)) else $error("Store missing on X bus");
chk_no_wb_load: assert property (
	op_valid && (op_code == `OP_MPY || op_code == `OP_MPY_NEG || op_code == `OP_ADD)
	|=> !xw_valid) else $error("Write-back from an excluded operation");
endmodule // dsp_post_props

bind dsp_accumulator_saturate_round_shift dsp_post_props u_props
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .op_valid(op_valid), .op_code(op_code),
	.op_target(op_target), .op_addr(op_addr), .xw_valid(xw_valid), .xw_addr(xw_addr),
	.acc_a_saturated_flag(acc_a_saturated_flag), .acc_b_saturated_flag(acc_b_saturated_flag),
	.acc_a_guard_overflow_flag(acc_a_guard_overflow_flag),
	.acc_b_guard_overflow_flag(acc_b_guard_overflow_flag),
	.either_guard_overflow_flag(either_guard_overflow_flag),
	.either_saturated_flag(either_saturated_flag), .arith_trap(arith_trap)
);

// *** verification/x_bus_model.sv ***
// Behavioural X data memory on the far side of the store port
`timescale 1ns/100ps

module x_bus_model
(
	input  wire        pclk,
	input  wire        xw_valid,
	input  wire [15:0] xw_addr,
	input  wire [15:0] xw_data,
	input  wire [15:0] rd_addr,
	output wire [15:0] x_rdata
);
reg     [15:0] mem [0:255];
integer        i;

// Cleared store so a shift never reads an unknown word
initial
	for (i = 0; i < 256; i = i + 1)
		mem[i] = 16'h0000;

// Word writes land at the sampling edge, like a real memory port
always @(posedge pclk)
	if (xw_valid)
		mem[xw_addr[7:0]] <= xw_data;

assign x_rdata = mem[rd_addr[7:0]];
endmodule // x_bus_model

// *** verification/tb_top.sv ***
// Self-checking bench: APB and operation sequences with expected results
`timescale 1ns/100ps
`include "dsp_post_defines.vh"

module tb_top;
reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
reg         op_valid = 1'b0, op_target = 1'b0, op_wb_en = 1'b0, op_wb_indirect = 1'b0;
reg         shift_arith = 1'b0, shift_mcu = 1'b0, slv, xv;
reg  [7:0]  paddr = 8'h00;
reg  [31:0] pwdata = 32'h0, rd;
reg  [2:0]  op_code = 3'h0;
reg  [39:0] op_operand = 40'h0, av;
reg  [15:0] op_addr = 16'h0, xa, xd;
reg  [4:0]  shift_count = 5'h0;
reg  [1:0]  shift_src = 2'h0;
reg  [71:0] rt [0:10];
reg  [85:0] st [0:4];
wire [31:0] prdata;
wire [15:0] xw_addr, xw_data, x_rdata;
wire        pready, pslverr, xw_valid, sa, sb, ga, gb, eg, es, trap;
integer     n_fail = 0, n_compared = 0, k;

// 50 MHz clock
always #10 pclk = ~pclk;

dsp_accumulator_saturate_round_shift DUT
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.op_valid(op_valid), .op_code(op_code), .op_target(op_target), .op_operand(op_operand),
	.op_wb_en(op_wb_en), .op_wb_indirect(op_wb_indirect), .op_addr(op_addr),
	.shift_count(shift_count), .shift_src(shift_src), .shift_arith(shift_arith),
	.shift_mcu(shift_mcu), .x_rdata(x_rdata), .xw_valid(xw_valid), .xw_addr(xw_addr),
	.xw_data(xw_data), .acc_a_saturated_flag(sa), .acc_b_saturated_flag(sb),
	.acc_a_guard_overflow_flag(ga), .acc_b_guard_overflow_flag(gb),
	.either_guard_overflow_flag(eg), .either_saturated_flag(es), .arith_trap(trap)
);

// Shifts always read the word at 0x0080
x_bus_model u_xbus
(
	.pclk(pclk), .xw_valid(xw_valid), .xw_addr(xw_addr), .xw_data(xw_data),
	.rd_addr(16'h0080), .x_rdata(x_rdata)
);

////////////////////////////////////////////////////////////////////////
task check(input [39:0] got, input [39:0] exp);
begin
	n_compared = n_compared + 1;
	if (got !== exp)
	begin
		n_fail = n_fail + 1;
		$display("[FAIL] %0t got %h expected %h", $time, got, exp);
	end
end
endtask

task report_and_stop;
begin
	$display("compared %0d failed %0d", n_compared, n_fail);
	if (n_fail == 0 && n_compared > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
end
endtask

// One APB transfer; an idle edge before setup keeps drives one per step
task apb(input w, input [7:0] a, input [31:0] d);
	integer i;
begin
	@(posedge pclk);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	@(posedge pclk);
	for (i = 0; pready !== 1'b1 && i < 20; i = i + 1)
		@(posedge pclk);
	if (pready !== 1'b1)
	begin
		n_fail = n_fail + 1;
		report_and_stop;
	end
	rd = prdata;
	slv = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
end
endtask

task rdacc(input [7:0] lo);
begin
	apb(1'b0, lo, 32'h0);
	av[31:0] = rd;
	apb(1'b0, lo + 8'h04, 32'h0);
	av[39:32] = rd[7:0];
end
endtask

// One operation pulse; sh packs mcu, arith, source and count
task op(input [2:0] c, input t, input [39:0] v, input w, input ind, input [15:0] a,
	input [8:0] sh);
begin
	@(posedge pclk);
	op_valid <= 1'b1;
	op_code <= c;
	op_target <= t;
	op_operand <= v;
	op_wb_en <= w;
	op_wb_indirect <= ind;
	op_addr <= a;
	{shift_mcu, shift_arith, shift_src, shift_count} <= sh;
	@(posedge pclk);
	op_valid <= 1'b0;
	#1;
	xv = xw_valid;
	xa = xw_addr;
	xd = xw_data;
end
endtask

////////////////////////////////////////////////////////////////////////
initial
begin
	rt[0] = {8'h00, 8'h06, 40'h0012348000, 16'h1235};
	rt[1] = {8'h01, 8'h06, 40'h0012348000, 16'h1234};
	rt[2] = {8'h01, 8'h06, 40'h0012358000, 16'h1236};
	rt[3] = {8'h01, 8'h06, 40'h0012348001, 16'h1235};
	rt[4] = {8'h00, 8'h06, 40'h0012347FFF, 16'h1234};
	rt[5] = {8'h00, 8'h05, 40'h001234FFFF, 16'h1234};
	rt[6] = {8'h02, 8'h05, 40'h0080000000, 16'h7FFF};
	rt[7] = {8'h02, 8'h05, 40'hFF7FFF0000, 16'h8000};
	rt[8] = {8'h00, 8'h05, 40'h0080000000, 16'h8000};
	rt[9] = {8'h02, 8'h06, 40'h007FFF8000, 16'h7FFF};
	rt[10] = {8'h00, 8'h06, 40'h007FFF8000, 16'h8000};
	st[0] = {40'h8000000000, 5'd4, 1'b1, 40'hF800000000};
	st[1] = {40'h8000000000, 5'd4, 1'b0, 40'h0800000000};
	st[2] = {40'h8000000000, 5'd15, 1'b1, 40'hFFFF000000};
	st[3] = {40'h0000001234, 5'h10, 1'b0, 40'h0012340000};
	st[4] = {40'h0000001234, 5'd0, 1'b0, 40'h0000001234};
	repeat (12) @(posedge pclk);
	presetn <= 1'b1;
	// Reset values and an unmapped address
	apb(1'b0, `REG_CORE_CONFIG, 32'h0);
	check(rd, 32'h0);
	apb(1'b0, 8'h20, 32'h0);
	check({slv, rd}, {1'b1, 32'h0});
	// 32-bit saturation on A, both signs, guard bits unused
	apb(1'b1, `REG_CORE_CONFIG, 32'h80);
	op(`OP_MPY, 1'b0, 40'h0080000000, 1'b0, 1'b0, 16'h0, 9'h0);
	check({sa, ga, eg, es}, 4'b1001);
	rdacc(`REG_ACC_A_LOW);
	check(av, 40'h007FFFFFFF);
	op(`OP_MPY, 1'b0, 40'hFF7FFFFFFF, 1'b0, 1'b0, 16'h0, 9'h0);
	check(ga, 1'b0);
	rdacc(`REG_ACC_A_LOW);
	check(av, 40'hFF80000000);
	// Flag survives a clean pass and clears only by software
	op(`OP_MPY, 1'b0, 40'h1, 1'b0, 1'b0, 16'h0, 9'h0);
	check(sa, 1'b1);
	apb(1'b1, `REG_STATUS, 32'h1);
	apb(1'b0, `REG_STATUS, 32'h0);
	check(rd[0], 1'b0);
	// 40-bit super saturation
	apb(1'b1, `REG_CORE_CONFIG, 32'h90);
	op(`OP_MPY, 1'b0, 40'h7FFFFFFFFF, 1'b0, 1'b0, 16'h0, 9'h0);
	op(`OP_ADD, 1'b0, 40'h1, 1'b0, 1'b0, 16'h0, 9'h0);
	check({sa, ga, eg, es}, 4'b1111);
	rdacc(`REG_ACC_A_LOW);
	check(av, 40'h7FFFFFFFFF);
	op(`OP_MPY, 1'b0, 40'h8000000000, 1'b0, 1'b0, 16'h0, 9'h0);
	op(`OP_MSC, 1'b0, 40'h1, 1'b0, 1'b0, 16'h0, 9'h0);
	rdacc(`REG_ACC_A_LOW);
	check(av, 40'h8000000000);
	// Saturation off: bit 31 is ignored, bit 39 wraps and traps
	apb(1'b1, `REG_STATUS, 32'h3);
	apb(1'b1, `REG_CORE_CONFIG, 32'h0);
	apb(1'b1, `REG_INTERRUPT_CTRL, 32'h1);
	op(`OP_MPY, 1'b0, 40'h0080000000, 1'b0, 1'b0, 16'h0, 9'h0);
	check({sa, ga, trap}, 3'b000);
	op(`OP_MPY, 1'b1, 40'h7FFFFFFFFF, 1'b0, 1'b0, 16'h0, 9'h0);
	op(`OP_ADD, 1'b1, 40'h1, 1'b0, 1'b0, 16'h0, 9'h0);
	check({sb, gb, trap}, 3'b111);
	rdacc(`REG_ACC_B_LOW);
	check(av, 40'h8000000000);
	apb(1'b1, `REG_INTERRUPT_CTRL, 32'h0);
	apb(1'b0, `REG_STATUS, 32'h0);
	check({rd[6], rd[5], rd[1]}, 3'b011);
	// Round and data-write saturation; the source stays intact
	for (k = 0; k < 11; k = k + 1)
	begin
		apb(1'b1, `REG_CORE_CONFIG, {24'h0, rt[k][71:64]});
		op(`OP_MPY, 1'b0, rt[k][55:16], 1'b0, 1'b0, 16'h0, 9'h0);
		op(rt[k][58:56], 1'b0, 40'h0, 1'b0, 1'b0, 16'h0040, 9'h0);
		check({xv, xa, xd}, {1'b1, 16'h0040, rt[k][15:0]});
		rdacc(`REG_ACC_A_LOW);
		check(av, rt[k][55:16]);
	end
	// Write-back of the other accumulator, both modes, excluded op
	apb(1'b1, `REG_CORE_CONFIG, 32'h0);
	apb(1'b1, `REG_WB_POINTER, 32'h0100);
	op(`OP_MPY, 1'b1, 40'h0012348000, 1'b0, 1'b0, 16'h0, 9'h0);
	op(`OP_MPY, 1'b0, 40'h0, 1'b1, 1'b1, 16'h0, 9'h0);
	check(xv, 1'b0);
	op(`OP_MAC, 1'b0, 40'h1, 1'b1, 1'b1, 16'h0, 9'h0);
	check({xv, xa, xd}, {1'b1, 16'h0100, 16'h1235});
	apb(1'b0, `REG_WB_POINTER, 32'h0);
	check(rd, 32'h0102);
	op(`OP_MSC, 1'b0, 40'h1, 1'b1, 1'b0, 16'h0, 9'h0);
	apb(1'b0, `REG_WB_POINTER, 32'h0);
	check(rd, 32'h1235);
	// Accumulator shifts from A into B
	for (k = 0; k < 5; k = k + 1)
	begin
		op(`OP_MPY, 1'b0, st[k][85:46], 1'b0, 1'b0, 16'h0, 9'h0);
		op(`OP_SHIFT, 1'b1, 40'h0, 1'b0, 1'b0, 16'h0, {1'b0, st[k][40], 2'd0, st[k][45:41]});
		rdacc(`REG_ACC_B_LOW);
		check(av, st[k][39:0]);
	end
	// X word stored, then shifted as a 16-bit result
	op(`OP_MPY, 1'b0, 40'h0084210000, 1'b0, 1'b0, 16'h0, 9'h0);
	op(`OP_SAC, 1'b0, 40'h0, 1'b0, 1'b0, 16'h0080, 9'h0);
	op(`OP_SHIFT, 1'b0, 40'h0, 1'b0, 1'b0, 16'h0090, {2'b11, 2'd2, 5'd4});
	check({xa, xd}, {16'h0090, 16'hF842});
	op(`OP_SHIFT, 1'b0, 40'h0, 1'b0, 1'b0, 16'h0090, {2'b10, 2'd2, 5'd4});
	check(xd, 16'h0842);
	op(`OP_SHIFT, 1'b0, 40'h0, 1'b0, 1'b0, 16'h0090, {2'b10, 2'd3, 5'h1C});
	check(xd, 16'h4210);
	report_and_stop;
end
endmodule // tb_top
